//--- logic/sre_read_engine.sv
// Purpose: 2-wire eeprom target, read side and word address counter
// Assumes: scl and sda come from the pins unsynchronised
// Notes: scl is sampled by clk, the bus side has no reset pin
// Function
// - read bit high in address means read
// - counter holds last access plus one
// - counter kept between transactions
// - read increment wraps last byte to zero
// - write increment wraps within same page
// - after read address ack, send counter byte
// - repeated start then read address
// - random read: ack address, send byte
// - ack low after byte: increment, send next
// - nack then stop ends read, idle
// - address 1010, select pins, direction bit
// - ack by pulling sda on ninth clock
// - pages 32 bytes, low five bits wrap
// - address mismatch: no ack, standby
`timescale 1ns/1ps
`default_nettype none
`include "sre_cfg.svh"
module sre_read_engine (
  input wire logic clk,
  input wire logic reset,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic select_pin_high,
  input wire logic select_pin_mid,
  input wire logic select_pin_low
);
  import sre_pkg::*;

  // ==========================================================
  // pin synchronisers
  sre_line_type line_meta, line, prev;
  logic [2:0] sel_meta, sel;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      line_meta <= `SRE_LINE_IDLE;
      line <= `SRE_LINE_IDLE;
      prev <= `SRE_LINE_IDLE;
      sel_meta <= `SRE_SELECT_RESET;
      sel <= `SRE_SELECT_RESET;
    end else begin
      line_meta <= {scl, sda_in};
      line <= line_meta;
      prev <= line;
      sel_meta <= {select_pin_high, select_pin_mid, select_pin_low};
      sel <= sel_meta;
    end
  end

  logic rise, fall, start, stop;
  assign rise = line.scl && !prev.scl;
  assign fall = !line.scl && prev.scl;
  // sda moving while scl stays high marks start and stop
  assign start = line.scl && prev.scl && prev.sda && !line.sda;
  assign stop = line.scl && prev.scl && !prev.sda && line.sda;

  // open drain: the pin is only ever pulled low
  assign sda_out = 1'b0;

  function automatic logic addr_match(input logic [7:0] b, input logic [2:0] s);
    addr_match = (b[7:4] == `SRE_DEV_PATTERN) && (b[3:1] == s);
  endfunction : addr_match

  // ==========================================================
  // fifo and memory
  sre_mem_req_type mem_req;
  logic [`SRE_DATA_W-1:0] mem_rd_data, fifo_data;
  logic mem_rd_valid, fifo_in_ready, fifo_out_valid, fifo_pop;
  logic rd_active;

  sre_mem i_sre_mem (
    .clk(clk),
    .reset(reset),
    .req(mem_req),
    .rd_data(mem_rd_data),
    .rd_valid(mem_rd_valid)
  );

  // the fifo hides memory latency from the short scl low time
  sre_fifo #(
    .WIDTH(`SRE_DATA_W),
    .DEPTH(`SRE_FIFO_DEPTH)
  ) i_sre_fifo (
    .clk(clk),
    .reset(reset),
    .flush(!rd_active),
    .in_valid(mem_rd_valid && rd_active),
    .in_ready(fifo_in_ready),
    .in_data(mem_rd_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // ==========================================================
  // protocol state
  sre_state_type state, next_state;
  sre_ack_type ack_to, next_ack_to;
  logic [3:0] cnt, next_cnt;
  logic [7:0] shin, next_shin, shout, next_shout;
  logic [`SRE_ADDR_W-1:0] word_addr, next_word;
  logic next_drive_n, next_rd_active, acked, next_acked;
  logic wr_fire;

  always_comb begin
    next_state = state;
    next_ack_to = ack_to;
    next_cnt = cnt;
    next_shin = shin;
    next_shout = shout;
    next_word = word_addr;
    next_drive_n = sda_oe_n;
    next_rd_active = rd_active;
    next_acked = acked;
    wr_fire = 1'b0;
    fifo_pop = 1'b0;
    if (start) begin
      next_state = S_ADDR;
      next_cnt = 4'h0;
      next_drive_n = 1'b1;
      next_rd_active = 1'b0;
    end else if (stop) begin
      next_state = S_IDLE;
      next_drive_n = 1'b1;
      next_rd_active = 1'b0;
    end else begin
      case (state)
        S_IDLE: begin
          next_drive_n = 1'b1;
        end
        S_ADDR, S_WHI, S_WLO, S_WDATA: begin
          if (rise) begin
            next_shin = {shin[6:0], line.sda};
            next_cnt = cnt + 4'h1;
          end else if (fall && cnt == `SRE_LAST_BIT) begin
            next_cnt = 4'h0;
            next_state = S_ACK;
            next_drive_n = 1'b0;
            case (state)
              S_ADDR: begin
                if (!addr_match(shin, sel)) begin
                  next_state = S_IDLE;
                  next_drive_n = 1'b1;
                end else if (shin[0]) begin
                  next_ack_to = K_READ;
                  next_rd_active = 1'b1;
                end else begin
                  next_ack_to = K_WHI;
                end
              end
              S_WHI: begin
                // upper address bits beyond the array are dropped
                next_word[11:8] = shin[3:0];
                next_ack_to = K_WLO;
              end
              S_WLO: begin
                next_word[7:0] = shin;
                next_ack_to = K_WDATA;
              end
              default: begin
                wr_fire = 1'b1;
                next_word[`SRE_PAGE_BITS-1:0] =
                  word_addr[`SRE_PAGE_BITS-1:0] + 1'b1;
                next_ack_to = K_WDATA;
              end
            endcase
          end
        end
        S_ACK: begin
          if (fall) begin
            next_drive_n = 1'b1;
            case (ack_to)
              K_READ: next_state = S_RD_LOAD;
              K_WHI: next_state = S_WHI;
              K_WLO: next_state = S_WLO;
              default: next_state = S_WDATA;
            endcase
          end
        end
        S_RD_LOAD: begin
          // limitation: a byte not ready before scl rises goes out on a later scl clock
          if (!line.scl && fifo_out_valid) begin
            fifo_pop = 1'b1;
            next_shout = fifo_data;
            next_drive_n = fifo_data[7];
            next_cnt = 4'h0;
            next_state = S_RD;
          end
        end
        S_RD: begin
          if (rise) begin
            next_cnt = cnt + 4'h1;
          end else if (fall) begin
            if (cnt == `SRE_LAST_BIT) begin
              next_drive_n = 1'b1;
              next_state = S_RACK;
            end else begin
              next_shout = {shout[6:0], 1'b0};
              next_drive_n = shout[6];
            end
          end
        end
        S_RACK: begin
          if (rise) begin
            next_acked = !line.sda;
            next_word = word_addr + 1'b1;
          end else if (fall) begin
            if (acked) begin
              next_state = S_RD_LOAD;
            end else begin
              next_state = S_IDLE;
              next_rd_active = 1'b0;
            end
          end
        end
        default: begin
          next_state = S_IDLE;
        end
      endcase
    end
  end

  // word_addr has no clear path besides reset: it survives every stop
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= S_IDLE;
      ack_to <= K_READ;
      cnt <= 4'h0;
      shin <= 8'h00;
      shout <= 8'h00;
      word_addr <= 12'h000;
      sda_oe_n <= 1'b1;
      rd_active <= 1'b0;
      acked <= 1'b0;
    end else begin
      state <= next_state;
      ack_to <= next_ack_to;
      cnt <= next_cnt;
      shin <= next_shin;
      shout <= next_shout;
      word_addr <= next_word;
      sda_oe_n <= next_drive_n;
      rd_active <= next_rd_active;
      acked <= next_acked;
    end
  end

  // ==========================================================
  // prefetch
  logic [`SRE_ADDR_W-1:0] pf_addr, next_pf_addr;
  logic pf_busy, next_pf_busy, issue;
  // one read in flight at most, so the fifo room seen at issue holds
  assign issue = rd_active && !pf_busy && fifo_in_ready && !wr_fire;
  always_comb begin
    next_pf_addr = pf_addr;
    next_pf_busy = 1'b0;
    mem_req.we = wr_fire;
    mem_req.re = issue;
    mem_req.wdata = shin;
    mem_req.addr = wr_fire ? word_addr : pf_addr;
    if (!rd_active) begin
      next_pf_addr = word_addr;
    end else if (issue) begin
      next_pf_busy = 1'b1;
      next_pf_addr = pf_addr + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pf_addr <= 12'h000;
      pf_busy <= 1'b0;
    end else begin
      pf_addr <= next_pf_addr;
      pf_busy <= next_pf_busy;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_ack_on_match: assert property (
    state == S_ADDR && !start && !stop && fall && cnt == `SRE_LAST_BIT
      && addr_match(shin, sel) |=> !sda_oe_n && state == S_ACK)
    else $error("matching address not acknowledged");
  a_nack_mismatch: assert property (
    state == S_ADDR && !start && !stop && fall && cnt == `SRE_LAST_BIT
      && !addr_match(shin, sel) |=> sda_oe_n && state == S_IDLE)
    else $error("mismatching address acknowledged");
  a_read_sets_active: assert property (
    state == S_ADDR && !start && !stop && fall && cnt == `SRE_LAST_BIT
      && addr_match(shin, sel) && shin[0] |=> rd_active && ack_to == K_READ)
    else $error("read address did not start a read");
  a_read_incr: assert property (
    state == S_RACK && rise && !start && !stop
      |=> word_addr == $past(word_addr) + 12'h001)
    else $error("read counter did not step by one");
  a_write_wrap: assert property (
    state == S_WDATA && !start && !stop && fall && cnt == `SRE_LAST_BIT
      |=> word_addr[11:5] == $past(word_addr[11:5])
        && word_addr[4:0] == $past(word_addr[4:0]) + 5'h01)
    else $error("write counter left its page");
  a_msb_first: assert property (
    state == S_RD_LOAD && !start && !stop && !line.scl && fifo_out_valid
      |=> sda_oe_n == $past(fifo_data[7]) && shout == $past(fifo_data))
    else $error("first data bit is not the msb");
  a_change_scl_low: assert property (
    $changed(sda_oe_n) && $past(state) != S_IDLE
      && !$past(start) && !$past(stop) |-> !prev.scl)
    else $error("sda moved while scl high");
  a_stop_idle: assert property (
    stop |=> state == S_IDLE && sda_oe_n && !rd_active ##1 sda_oe_n)
    else $error("stop did not release the line");
  a_nack_ends: assert property (
    state == S_RACK && !acked && fall && !start && !stop
      |=> state == S_IDLE && sda_oe_n)
    else $error("nack did not end the read");
  a_addr_held: assert property (
    state == S_IDLE && !start |=> $stable(word_addr))
    else $error("counter moved while idle");
  a_word_load: assert property (
    state == S_WLO && !start && !stop && fall && cnt == `SRE_LAST_BIT
      |=> word_addr[7:0] == $past(shin))
    else $error("low word address not loaded");
  c_random_read: cover property (state == S_ACK && ack_to == K_WLO ##[1:1000] state == S_RD);
  c_seq_wrap: cover property (state == S_RACK && rise && !line.sda && word_addr == 12'hfff);
  c_mismatch: cover property (state == S_ADDR ##1 state == S_IDLE && !stop);
  c_fifo_full: cover property (rd_active && !fifo_in_ready);
endmodule : sre_read_engine
`default_nettype wire

//--- logic/sre_cfg.svh
// Purpose: constants of the serial eeprom read engine
// Assumes: included by bare name, guard stops double inclusion
// Notes: widths, counts and the device address pattern
`ifndef SRE_CFG_SVH
`define SRE_CFG_SVH
`define SRE_ADDR_W 12
`define SRE_DATA_W 8
`define SRE_MEM_DEPTH 4096
`define SRE_PAGE_BITS 5
`define SRE_DEV_PATTERN 4'ha
`define SRE_FIFO_DEPTH 8
`define SRE_LAST_BIT 4'h8
`define SRE_SELECT_RESET 3'h0
`define SRE_LINE_IDLE 2'h3
`endif

//--- logic/sre_pkg.sv
// Purpose: types shared by the read engine files
// Assumes: sre_cfg.svh holds the address and data widths; enum widths are set here
// Notes: none
`default_nettype none
package sre_pkg;
`include "sre_cfg.svh"
  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_ACK, S_WHI, S_WLO, S_WDATA, S_RD_LOAD, S_RD, S_RACK
  } sre_state_type;
  typedef enum logic [1:0] {K_READ, K_WHI, K_WLO, K_WDATA} sre_ack_type;
  typedef struct packed {
    logic we;
    logic re;
    logic [`SRE_ADDR_W-1:0] addr;
    logic [`SRE_DATA_W-1:0] wdata;
  } sre_mem_req_type;
  typedef struct packed {
    logic scl;
    logic sda;
  } sre_line_type;
endpackage : sre_pkg
`default_nettype wire

//--- logic/sre_fifo.sv
// Purpose: small prefetch fifo between memory and shifter
// Assumes: flush empties it in one cycle
// Notes: full and empty come straight from the count
`timescale 1ns/1ps
`default_nettype none
module sre_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [PW:0] count, next_count;
  logic push, pop;
  assign in_ready = count != (PW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data = store[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (flush) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count = '0;
    end else begin
      if (push) next_wr_ptr = (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (pop) next_rd_ptr = (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      next_count = count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end
  always_ff @(posedge clk) begin
    if (push && !flush) store[wr_ptr] <= in_data;
  end
endmodule : sre_fifo
`default_nettype wire

//--- logic/sre_mem.sv
// Purpose: byte array behind the word address counter
// Assumes: one request a cycle, write or read
// Notes: read data arrives one cycle after the request
`timescale 1ns/1ps
`default_nettype none
`include "sre_cfg.svh"
module sre_mem (
  input wire logic clk,
  input wire logic reset,
  input wire sre_pkg::sre_mem_req_type req,
  output logic [`SRE_DATA_W-1:0] rd_data,
  output logic rd_valid
);
  import sre_pkg::*;
  logic [`SRE_DATA_W-1:0] cells [`SRE_MEM_DEPTH];
  always_ff @(posedge clk) begin
    if (req.we) cells[req.addr] <= req.wdata;
    if (req.re) rd_data <= cells[req.addr];
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) rd_valid <= 1'b0;
    else rd_valid <= req.re;
  end
endmodule : sre_mem
`default_nettype wire

//--- test/sre_ctrl_model.sv
// Purpose: 2-wire bus controller that talks to the read engine
// Assumes: scl period 48 ns, sda released means pulled up
// Notes: scl low 28 ns, high 20 ns; edges fall on whole ns, never on a clk rise
`timescale 1ns/1ps
`default_nettype none
module sre_ctrl_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_drv
);
  // the low phase is the longer one: the first read bit needs it to set up
  localparam int T_SET = 14;
  localparam int T_LOW = 28;
  localparam int T_HIGH = 20;
  // ==========================================================
  // idle bus: both lines released, scl stands still
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_clk

  // ==========================================================
  // conditions
  // also serves as the repeated start of a random read
  task automatic start_cond();
    sda_drv = 1'b1;
    #T_LOW;
    scl = 1'b1;
    #T_LOW;
    sda_drv = 1'b0;
    #T_LOW;
    scl = 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    #T_SET;
    sda_drv = 1'b0;
    #(T_LOW - T_SET);
    scl = 1'b1;
    #T_LOW;
    sda_drv = 1'b1;
    #T_LOW;
  endtask : stop_cond

  // ==========================================================
  // bits and bytes, msb first
  // data only changes in the low phase of scl
  task automatic bit_xfer(input logic b, output logic seen);
    #T_SET;
    sda_drv = b;
    #(T_LOW - T_SET);
    scl = 1'b1;
    #T_HIGH;
    seen = sda;
    scl = 1'b0;
  endtask : bit_xfer

  // direction bit travels as the lsb of the address byte
  task automatic send_byte(input logic [7:0] b, output logic acked);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(b[i], s);
    end
    bit_xfer(1'b1, s);
    acked = (s === 1'b0);
  endtask : send_byte

  // more = 1 acks the byte, more = 0 leaves the line high
  task automatic recv_byte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, d[i]);
    end
    bit_xfer(!more, s);
  endtask : recv_byte
endmodule : sre_ctrl_model
`default_nettype wire

//--- test/sre_read_engine_test.sv
// Purpose: self-checking bench of the read engine
// Assumes: memory is written through the bus before any read
// Notes: the controller model runs scl with a 48 ns period
`timescale 1ns/1ps
`default_nettype none
module sre_read_engine_test;
  logic clk;
  logic reset;
  logic scl;
  logic sda_drv;
  logic sda_out;
  logic sda_oe_n;
  logic sda;
  logic [2:0] sel;
  int n_errors;
  int checks_done;

  // open drain wire with pull-up
  assign sda = sda_drv & (sda_oe_n ? 1'b1 : sda_out);

  sre_read_engine i_sre_read_engine (
    .clk(clk), .reset(reset), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .select_pin_high(sel[2]), .select_pin_mid(sel[1]), .select_pin_low(sel[0])
  );

  sre_ctrl_model i_sre_ctrl_model (.clk(clk), .sda(sda), .scl(scl), .sda_drv(sda_drv));

  // ==========================================================
  // helpers
  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask : check

  task automatic send_exp(input logic [7:0] b, input logic exp_ack, input string what);
    logic k;
    i_sre_ctrl_model.send_byte(b, k);
    check(what, {7'h0, exp_ack}, {7'h0, k});
  endtask : send_exp

  task automatic read_exp(input logic [7:0] exp, input logic more, input string what);
    logic [7:0] d;
    i_sre_ctrl_model.recv_byte(more, d);
    check(what, exp, d);
  endtask : read_exp

  // dummy write: address only, no data, leaves the bus open
  task automatic set_addr(input logic [7:0] hi, input logic [7:0] lo);
    i_sre_ctrl_model.start_cond();
    send_exp(8'ha0, 1'b1, "write address ack");
    send_exp(hi, 1'b1, "word address high ack");
    send_exp(lo, 1'b1, "word address low ack");
  endtask : set_addr

  task automatic write_run(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] base, input int n);
    set_addr(hi, lo);
    for (int i = 0; i < n; i++) begin
      send_exp(base + 8'(i), 1'b1, "data byte ack");
    end
    i_sre_ctrl_model.stop_cond();
  endtask : write_run

  // ==========================================================
  // scenarios
  task automatic t_page_wrap();
    write_run(8'h00, 8'h1e, 8'ha0, 6);
    write_run(8'h0f, 8'hfe, 8'h50, 3);
    set_addr(8'h00, 8'h00);
    i_sre_ctrl_model.start_cond();
    send_exp(8'ha1, 1'b1, "read address ack");
    read_exp(8'ha2, 1'b0, "byte after page wrap");
    i_sre_ctrl_model.stop_cond();
    set_addr(8'h0f, 8'he0);
    i_sre_ctrl_model.start_cond();
    send_exp(8'ha1, 1'b1, "read address ack");
    read_exp(8'h52, 1'b0, "top page wrap byte");
    i_sre_ctrl_model.stop_cond();
  endtask : t_page_wrap

  // upper nibble of the high address byte must be ignored
  task automatic t_seq_wrap();
    set_addr(8'hff, 8'hfe);
    i_sre_ctrl_model.start_cond();
    send_exp(8'ha1, 1'b1, "read address ack");
    read_exp(8'h50, 1'b1, "byte at ffe");
    read_exp(8'h51, 1'b1, "byte at fff");
    read_exp(8'ha2, 1'b1, "byte at 000");
    read_exp(8'ha3, 1'b0, "byte at 001");
    i_sre_ctrl_model.stop_cond();
  endtask : t_seq_wrap

  task automatic t_current();
    i_sre_ctrl_model.start_cond();
    send_exp(8'ha1, 1'b1, "current read address ack");
    read_exp(8'ha4, 1'b0, "current address byte");
    i_sre_ctrl_model.stop_cond();
  endtask : t_current

  task automatic t_select();
    i_sre_ctrl_model.start_cond();
    send_exp(8'ha3, 1'b0, "wrong select nack");
    i_sre_ctrl_model.stop_cond();
    i_sre_ctrl_model.start_cond();
    send_exp(8'hb1, 1'b0, "wrong pattern nack");
    i_sre_ctrl_model.stop_cond();
    i_sre_ctrl_model.wait_clk(10);
    sel = 3'h5;
    i_sre_ctrl_model.start_cond();
    send_exp(8'hab, 1'b1, "strapped select ack");
    read_exp(8'ha5, 1'b0, "byte after refused addresses");
    i_sre_ctrl_model.stop_cond();
  endtask : t_select

  // ==========================================================
  // clock, reset, watchdog, main sequence
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    #200000;
    n_errors++;
    close_out();
  end

  initial begin
    n_errors = 0;
    checks_done = 0;
    reset = 1'b1;
    sel = 3'h0;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    repeat (6) @(negedge clk);
    t_page_wrap();
    t_seq_wrap();
    t_current();
    t_select();
    close_out();
  end
endmodule : sre_read_engine_test
`default_nettype wire
